//--- sensor_pd_pkg.sv
package sensor_pd_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [6:0] CFG_ADDR = 7'h00;       // power configuration register address
   localparam int SLEEP_BIT = 6;                    // sleep control bit position
   localparam logic [7:0] CFG_RESET = 8'h00;      // configuration value after reset

   // ************************************************************
   // serial framing
   // ************************************************************
   localparam logic [4:0] ADDR_LAST = 5'h07;      // bit index of last address bit
   localparam logic [4:0] DATA_FIRST = 5'h08;     // bit index of first data bit
   localparam logic [4:0] DATA_LAST = 5'h0F;      // bit index of last data bit

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 5;               // system clock period
   localparam int SLEEP_ENTRY_WAIT_CLK = 32;       // host pause after a sleep write
   localparam int STARTUP_US = 610;                // analog startup interval
   localparam int STARTUP_CYC = STARTUP_US * 1000 / CLK_PERIOD_NS;
   localparam int FRAME_RATE_FPS = 1500;           // frame rate
   localparam int FRAME_CYC = 1000000000 / (FRAME_RATE_FPS * CLK_PERIOD_NS);
   localparam int TIMEOUT_MS = 90;                 // serial transaction timer
   localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
   localparam logic [6:0] SUPPLY_FRAMES = 7'h32;  // frames to settle after supply up
   localparam logic [6:0] WAKE_FRAMES = 7'h4B;    // frames to settle after wake
   localparam int SETTLE_W = 18;                   // settle counter width
   localparam int TMO_W = 25;                      // timeout counter width

   // ************************************************************
   // power sequencer states
   // ************************************************************
   typedef enum logic [3:0] {
      ST_SUPPLY_SETTLE = 4'h1,
      ST_RUN = 4'h2,
      ST_SLEEP = 4'h4,
      ST_WAKE_SETTLE = 4'h8
   } power_state_t;

endpackage

//--- serial_link_if.sv
interface serial_link_if;
   logic cfg_wr;        // one-cycle pulse: a full write has been received
   logic [6:0] addr;    // register address of the current transaction
   logic [7:0] wdata;   // data byte of a completed write
   logic [7:0] rdata;   // data returned for a read
   logic active;        // a transaction is in progress
   logic drive;         // shifter wants to drive the data line
   logic out_bit;       // bit to drive on the data line
   logic port_reset;    // abort the current transaction
   logic sleep;         // power-down is in force

   modport port (output cfg_wr, addr, wdata, active, drive, out_bit,
                 input rdata, port_reset, sleep);
   modport core (input cfg_wr, addr, wdata, active, drive, out_bit,
                 output rdata, port_reset, sleep);
endinterface

//--- serial_shifter.sv
module serial_shifter (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // serial pins
   input wire logic sck,
   input wire logic sdio_in,
   // toward the power core
   serial_link_if.port link
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic sck_meta;      // first synchroniser stage
      logic sck_sync;      // second synchroniser stage
      logic sck_prev;      // delayed copy for edge detect
      logic sdio_meta;     // first synchroniser stage
      logic sdio_sync;     // second synchroniser stage
      logic [4:0] bit_cnt; // bits seen in this transaction
      logic [7:0] rx;      // receive shift register
      logic [7:0] tx;      // transmit shift register
      logic [6:0] addr;    // captured address
      logic is_read;       // transaction direction
      logic drive;         // driving the data line
      logic cfg_wr;        // write complete pulse
   } shifter_t;

   shifter_t s;
   shifter_t next_s;
   logic rise;
   logic fall;

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic [7:0] rx_new;
      rx_new = {s.rx[6:0], s.sdio_sync};
      next_s = s;
      next_s.sck_meta = sck;
      next_s.sck_sync = s.sck_meta;
      next_s.sck_prev = s.sck_sync;
      next_s.sdio_meta = sdio_in;
      next_s.sdio_sync = s.sdio_meta;
      next_s.cfg_wr = 1'b0;
      rise = s.sck_sync & ~s.sck_prev;
      fall = ~s.sck_sync & s.sck_prev;
      if (link.port_reset) begin
         // timer expired: start over from the address byte
         next_s.bit_cnt = 5'h00;
         next_s.drive = 1'b0;
      end else if (rise) begin
         // host data sampled on rising edges
         next_s.rx = rx_new;
         if (s.bit_cnt == sensor_pd_pkg::ADDR_LAST) begin
            // address byte done; its top bit gives the direction
            next_s.addr = rx_new[6:0];
            next_s.is_read = ~rx_new[7];
            next_s.bit_cnt = s.bit_cnt + 5'h01;
         end else if (s.bit_cnt == sensor_pd_pkg::DATA_LAST) begin
            // last data bit: a write takes effect only now
            next_s.bit_cnt = 5'h00;
            next_s.cfg_wr = ~s.is_read;
         end else begin
            next_s.bit_cnt = s.bit_cnt + 5'h01;
         end
      end else if (fall) begin
         if (s.is_read && !s.drive && s.bit_cnt == sensor_pd_pkg::DATA_FIRST) begin
            // host has let go: load and start driving read data
            next_s.drive = 1'b1;
            next_s.tx = link.rdata;
         end else if (s.drive && s.bit_cnt > sensor_pd_pkg::DATA_FIRST) begin
            // next data bit
            next_s.tx = {s.tx[6:0], 1'b0};
         end else if (s.drive && s.bit_cnt == 5'h00) begin
            // last bit held until this falling edge
            next_s.drive = 1'b0;
         end
      end
      // power-down releases the data line
      if (link.sleep) begin
         next_s.drive = 1'b0;
      end
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign link.cfg_wr = s.cfg_wr;
   assign link.addr = s.addr;
   assign link.wdata = s.rx;
   assign link.active = (s.bit_cnt != 5'h00);
   assign link.drive = s.drive;
   assign link.out_bit = s.tx[7];

   // ************************************************************
   // checks
   // ************************************************************
   chk_write_full_byte: assert property (@(posedge sys_clk) disable iff (!rstn)
      s.cfg_wr |-> ($past(s.bit_cnt) == sensor_pd_pkg::DATA_LAST) && !$past(s.is_read))
      else $error("write applied before the full data byte");
   chk_release_sleep: assert property (@(posedge sys_clk) disable iff (!rstn)
      link.sleep |=> !s.drive)
      else $error("data line still driven in power-down");

endmodule

//--- sensor_power_down_control.sv
// Contract
// - write bit 6 high enters power-down
// - write bit 6 low leaves power-down
// - transaction timer stops during power-down
// - asleep, writes change only bit 6
// - settings kept through power-down and wake
// - configuration register at address zero
// - shutter and data line tri-stated asleep
// - awake, stuck transaction resets after 90 ms
// - wake: startup plus 75 frames to valid
// - supply up: startup plus 50 frames
// - sleep cuts analog power, keeps registers
// - address byte MSB high means write
module sensor_power_down_control #(
   parameter int STARTUP_CYC = sensor_pd_pkg::STARTUP_CYC,
   parameter int FRAME_CYC = sensor_pd_pkg::FRAME_CYC,
   parameter int TIMEOUT_CYC = sensor_pd_pkg::TIMEOUT_CYC
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // serial port pins
   input wire logic sck,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   // illumination shutter pin
   output logic illuminator_shutter_out,
   output logic illuminator_shutter_oe,
   // status toward the analog and motion blocks
   output logic analog_power_en,
   output logic motion_valid,
   output logic sleep_mode
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      sensor_pd_pkg::power_state_t state;           // sequencer state
      logic [7:0] power_config;                     // configuration register
      logic [sensor_pd_pkg::SETTLE_W-1:0] settle_cnt; // cycles in current interval
      logic [6:0] frame_cnt;                        // frames counted so far
      logic [6:0] frame_goal;                       // frames needed to settle
      logic startup_done;                           // startup interval finished
      logic [sensor_pd_pkg::TMO_W-1:0] tmo_cnt;     // transaction timer
      logic port_reset;                             // timer expiry pulse
      logic sdio_out;                               // data line value
      logic sdio_oe;                                // data line enable
      logic shutter_out;                            // shutter value
      logic shutter_oe;                             // shutter enable
      logic analog_en;                              // analog supply enable
      logic motion_valid;                           // motion reports accurate
   } core_t;

   localparam core_t CORE_RESET = '{
      state: sensor_pd_pkg::ST_SUPPLY_SETTLE,
      power_config: sensor_pd_pkg::CFG_RESET,
      frame_goal: sensor_pd_pkg::SUPPLY_FRAMES,
      default: '0
   };

   core_t s;
   core_t next_s;
   logic sleep_req;
   serial_link_if link ();

   // ************************************************************
   // serial shifter
   // ************************************************************
   serial_shifter u_shifter (
      .sys_clk (sys_clk),
      .rstn (rstn),
      .sck (sck),
      .sdio_in (sdio_in),
      .link (link)
   );

   // read data: configuration at its address, zero elsewhere
   assign link.rdata = (link.addr == sensor_pd_pkg::CFG_ADDR) ? s.power_config : 8'h00;
   assign link.port_reset = s.port_reset;
   assign link.sleep = s.power_config[sensor_pd_pkg::SLEEP_BIT];

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      next_s = s;
      next_s.port_reset = 1'b0;
      // configuration write; other addresses ignored
      if (link.cfg_wr && link.addr == sensor_pd_pkg::CFG_ADDR) begin
         if (s.power_config[sensor_pd_pkg::SLEEP_BIT]) begin
            // asleep: only the sleep bit is writable
            next_s.power_config[sensor_pd_pkg::SLEEP_BIT] = link.wdata[sensor_pd_pkg::SLEEP_BIT];
         end else begin
            // awake: whole register, sleep bit included
            next_s.power_config = link.wdata;
         end
      end
      sleep_req = next_s.power_config[sensor_pd_pkg::SLEEP_BIT];

      // transaction timer
      if (s.power_config[sensor_pd_pkg::SLEEP_BIT]) begin
         // frozen in power-down; a partial command hangs the port
         next_s.tmo_cnt = s.tmo_cnt;
      end else if (!link.active) begin
         next_s.tmo_cnt = '0;
      end else if (s.tmo_cnt == sensor_pd_pkg::TMO_W'(TIMEOUT_CYC - 1)) begin
         // expired: abort the transaction
         next_s.tmo_cnt = '0;
         next_s.port_reset = 1'b1;
      end else begin
         next_s.tmo_cnt = s.tmo_cnt + sensor_pd_pkg::TMO_W'(1);
      end

      // power sequencer
      case (s.state)
         sensor_pd_pkg::ST_SUPPLY_SETTLE, sensor_pd_pkg::ST_WAKE_SETTLE: begin
            if (sleep_req) begin
               next_s.state = sensor_pd_pkg::ST_SLEEP;
            end else if (!s.startup_done) begin
               // analog startup interval
               if (s.settle_cnt == sensor_pd_pkg::SETTLE_W'(STARTUP_CYC - 1)) begin
                  next_s.settle_cnt = '0;
                  next_s.startup_done = 1'b1;
               end else begin
                  next_s.settle_cnt = s.settle_cnt + sensor_pd_pkg::SETTLE_W'(1);
               end
            end else if (s.settle_cnt == sensor_pd_pkg::SETTLE_W'(FRAME_CYC - 1)) begin
               // one frame elapsed
               next_s.settle_cnt = '0;
               if (s.frame_cnt == s.frame_goal - 7'h01) begin
                  // settle count complete: reports now accurate
                  next_s.state = sensor_pd_pkg::ST_RUN;
                  next_s.motion_valid = 1'b1;
               end else begin
                  next_s.frame_cnt = s.frame_cnt + 7'h01;
               end
            end else begin
               next_s.settle_cnt = s.settle_cnt + sensor_pd_pkg::SETTLE_W'(1);
            end
         end
         sensor_pd_pkg::ST_RUN: begin
            // normal operation
            if (sleep_req) begin
               next_s.state = sensor_pd_pkg::ST_SLEEP;
            end
         end
         sensor_pd_pkg::ST_SLEEP: begin
            // wake: restart settling with the longer frame count
            if (!sleep_req) begin
               next_s.state = sensor_pd_pkg::ST_WAKE_SETTLE;
               next_s.frame_goal = sensor_pd_pkg::WAKE_FRAMES;
               next_s.settle_cnt = '0;
               next_s.frame_cnt = 7'h00;
               next_s.startup_done = 1'b0;
            end
         end
         default: begin
            // illegal code: restart as from supply up
            next_s.state = sensor_pd_pkg::ST_SUPPLY_SETTLE;
            next_s.frame_goal = sensor_pd_pkg::SUPPLY_FRAMES;
            next_s.settle_cnt = '0;
            next_s.frame_cnt = 7'h00;
            next_s.startup_done = 1'b0;
         end
      endcase

      // entering sleep drops reports and counters, not settings
      if (next_s.state == sensor_pd_pkg::ST_SLEEP) begin
         next_s.motion_valid = 1'b0;
         next_s.settle_cnt = '0;
         next_s.frame_cnt = 7'h00;
      end

      // pin and analog controls
      next_s.analog_en = ~sleep_req;
      next_s.shutter_out = ~sleep_req;
      next_s.shutter_oe = ~sleep_req;
      next_s.sdio_out = link.out_bit;
      next_s.sdio_oe = link.drive & ~sleep_req;
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         s <= CORE_RESET;
      end else begin
         s <= next_s;
      end
   end

   assign sdio_out = s.sdio_out;
   assign sdio_oe = s.sdio_oe;
   assign illuminator_shutter_out = s.shutter_out;
   assign illuminator_shutter_oe = s.shutter_oe;
   assign analog_power_en = s.analog_en;
   assign motion_valid = s.motion_valid;
   assign sleep_mode = s.power_config[sensor_pd_pkg::SLEEP_BIT];

   // ************************************************************
   // checks
   // ************************************************************
   // a sleep write powers the analog side down at once
   chk_sleep_enter: assert property (@(posedge sys_clk) disable iff (!rstn)
      link.cfg_wr && link.addr == sensor_pd_pkg::CFG_ADDR && link.wdata[sensor_pd_pkg::SLEEP_BIT]
      |=> sleep_mode && !s.analog_en && s.state == sensor_pd_pkg::ST_SLEEP)
      else $error("sleep write did not enter power-down");

   // clearing the sleep bit leaves power-down
   chk_sleep_exit: assert property (@(posedge sys_clk) disable iff (!rstn)
      link.cfg_wr && link.addr == 7'h00 && !link.wdata[6] |=> !sleep_mode
      ##1 s.state == sensor_pd_pkg::ST_WAKE_SETTLE || s.state == sensor_pd_pkg::ST_RUN
      || s.state == sensor_pd_pkg::ST_SUPPLY_SETTLE)
      else $error("clearing the sleep bit did not leave power-down");

   // asleep, every bit but the sleep bit holds
   chk_sleep_mask: assert property (@(posedge sys_clk) disable iff (!rstn)
      sleep_mode && link.cfg_wr |=> s.power_config[7] == $past(s.power_config[7])
      && s.power_config[5:0] == $past(s.power_config[5:0]))
      else $error("asleep write changed a bit other than the sleep bit");

   // settings stand still through power-down
   chk_retain_config: assert property (@(posedge sys_clk) disable iff (!rstn)
      s.state == sensor_pd_pkg::ST_SLEEP && !link.cfg_wr |=> $stable(s.power_config))
      else $error("configuration lost during power-down");

   // writes elsewhere never touch the configuration
   chk_other_addr: assert property (@(posedge sys_clk) disable iff (!rstn)
      link.cfg_wr && link.addr != 7'h00 |=> $stable(s.power_config))
      else $error("write to another address changed the configuration");

   // the transaction timer holds while asleep
   chk_timer_frozen: assert property (@(posedge sys_clk) disable iff (!rstn)
      $past(sleep_mode) && sleep_mode |-> !s.port_reset && $stable(s.tmo_cnt))
      else $error("transaction timer ran in power-down");

   // expiry clears the shifter on the next cycle
   chk_timeout_abort: assert property (@(posedge sys_clk) disable iff (!rstn)
      s.port_reset |-> $past(s.tmo_cnt) == sensor_pd_pkg::TMO_W'(TIMEOUT_CYC - 1) ##1 !link.active)
      else $error("transaction timer expiry did not reset the port");

   // asleep, both pins float and the analog side is off
   chk_pins_tristate: assert property (@(posedge sys_clk) disable iff (!rstn)
      s.state == sensor_pd_pkg::ST_SLEEP |-> !sdio_oe && !illuminator_shutter_oe && !analog_power_en)
      else $error("pin driven or analog powered during power-down");

   // valid rises only at the end of the last frame
   chk_valid_frames: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(s.motion_valid) |-> $past(s.frame_cnt) == $past(s.frame_goal) - 7'h01
      && $past(s.startup_done) && s.state == sensor_pd_pkg::ST_RUN)
      else $error("motion valid before the settle count completed");

   // wake settling uses the longer frame count
   chk_wake_goal: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(s.state == sensor_pd_pkg::ST_WAKE_SETTLE) |-> s.frame_goal == 7'h4B && !s.motion_valid)
      else $error("wake settling not set for 75 frames");

   // supply settling uses the shorter frame count
   chk_supply_goal: assert property (@(posedge sys_clk) disable iff (!rstn)
      s.state == sensor_pd_pkg::ST_SUPPLY_SETTLE |-> s.frame_goal == 7'h32 && !s.motion_valid)
      else $error("supply settling not set for 50 frames");

   // the sleep bit only rises on a configuration write
   chk_sleep_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(sleep_mode) |-> $past(link.cfg_wr) && $past(link.addr) == sensor_pd_pkg::CFG_ADDR)
      else $error("sleep bit set without a configuration write");

   // the sleep bit only falls on a write of zero
   chk_wake_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
      $fell(sleep_mode) |-> $past(link.cfg_wr) && !$past(link.wdata[sensor_pd_pkg::SLEEP_BIT]))
      else $error("sleep bit cleared without a configuration write");

   // awake, the shutter pin is driven and the analog side powered
   chk_awake_drive: assert property (@(posedge sys_clk) disable iff (!rstn)
      $past(rstn) && !sleep_mode |-> illuminator_shutter_oe && illuminator_shutter_out && analog_power_en)
      else $error("shutter or analog side off while awake");

   // the data line is released whenever the shifter lets go
   chk_oe_follows: assert property (@(posedge sys_clk) disable iff (!rstn)
      !link.drive |=> !sdio_oe)
      else $error("data line driven without a read in progress");

   // awake and idle, the transaction timer stands at zero
   chk_timer_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
      !sleep_mode && !link.active |=> s.tmo_cnt == '0)
      else $error("transaction timer ran with no transaction");

   // startup ends only when its full interval is counted
   chk_startup_count: assert property (@(posedge sys_clk) disable iff (!rstn)
      $rose(s.startup_done) |-> $past(s.settle_cnt) == sensor_pd_pkg::SETTLE_W'(STARTUP_CYC - 1))
      else $error("startup interval ended early");

   // reports are only marked valid in normal operation
   chk_valid_run: assert property (@(posedge sys_clk) disable iff (!rstn)
      s.motion_valid |-> s.state == sensor_pd_pkg::ST_RUN)
      else $error("motion valid outside normal operation");

   // waking restarts every settle counter from zero
   chk_wake_restart: assert property (@(posedge sys_clk) disable iff (!rstn)
      $past(s.state) == sensor_pd_pkg::ST_SLEEP && s.state == sensor_pd_pkg::ST_WAKE_SETTLE
      |-> s.settle_cnt == '0 && s.frame_cnt == 7'h00 && !s.startup_done)
      else $error("wake did not restart settling");

endmodule

//--- serial_host_model.sv
// host side of the two-wire link: drives the serial clock and data line
module serial_host_model (
   // serial pins
   output logic sck,
   output logic sdio_drv,
   output logic sdio_en,
   // resolved level of the data line
   input wire logic sdio_wire
);
   timeunit 1ns;
   timeprecision 100ps;

   // ************************************************************
   // idle: clock stands high, data line released
   // ************************************************************
   initial begin
      sck = 1'b1;
      sdio_drv = 1'b0;
      sdio_en = 1'b0;
   end

   // one byte msb first; data changes while the clock is low
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         sdio_en = 1'b1;
         sdio_drv = b[i];
         #24;
         sck = 1'b1;
         #24;
      end
   endtask

   // full write: address byte with msb high, then the data byte
   task automatic write_reg(input logic [6:0] a, input logic [7:0] d);
      send_byte({1'b1, a});
      send_byte(d);
      #200;
   endtask

   // read: release the line after the address, long low phase per bit
   task automatic read_reg(input logic [6:0] a, output logic [7:0] d);
      send_byte({1'b0, a});
      sdio_en = 1'b0;
      #200;
      for (int i = 7; i >= 0; i--) begin
         sck = 1'b0;
         #60;
         sck = 1'b1;
         d[i] = sdio_wire;
         #24;
      end
      #100;
   endtask
endmodule

//--- sensor_power_down_control_test.sv
module sensor_power_down_control_test;
   timeunit 1ns;
   timeprecision 100ps;

   // ************************************************************
   // signals
   // ************************************************************
   logic sys_clk = 1'b0; // 200 MHz system clock
   logic rstn; // held low from time zero by the reset test
   logic sck, sdio_drv, sdio_en, sdio_wire;
   logic last_wire = 1'b0; // previous line level, for a floating line
   logic sdio_out, sdio_oe, illuminator_shutter_out, illuminator_shutter_oe;
   logic analog_power_en, motion_valid, sleep_mode;
   logic [7:0] rd; // read-back byte
   int mismatches = 0;
   int check_count = 0;

   // clock generator
   always #2.5 sys_clk = ~sys_clk;

   // data line: device, else host, else a released line flips
   assign sdio_wire = sdio_oe ? sdio_out : (sdio_en ? sdio_drv : ~last_wire);
   always @(posedge sys_clk) last_wire <= sdio_wire;

   // ************************************************************
   // instances
   // ************************************************************
   sensor_power_down_control #(.STARTUP_CYC(20), .FRAME_CYC(10), .TIMEOUT_CYC(400)) u_dut (
      .sys_clk(sys_clk), .rstn(rstn), .sck(sck), .sdio_in(sdio_wire),
      .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .illuminator_shutter_out(illuminator_shutter_out),
      .illuminator_shutter_oe(illuminator_shutter_oe),
      .analog_power_en(analog_power_en), .motion_valid(motion_valid), .sleep_mode(sleep_mode));
   serial_host_model u_host (.sck(sck), .sdio_drv(sdio_drv), .sdio_en(sdio_en), .sdio_wire(sdio_wire));

   // ************************************************************
   // compare and report
   // ************************************************************
   task automatic chk1(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // valid must still be low after n - 20 cycles, then rise within 40 more cycles
   task automatic settle_check(input int n);
      repeat (n - 20) @(negedge sys_clk);
      chk1(motion_valid, 1'b0);
      for (int k = 0; k < 40 && motion_valid !== 1'b1; k++) @(negedge sys_clk);
      chk1(motion_valid, 1'b1);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic test_reset();
      rstn = 1'b0;
      repeat (6) @(negedge sys_clk);
      chk1(analog_power_en, 1'b0);
      rstn = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk1(sleep_mode, 1'b0);
      chk1(illuminator_shutter_oe, 1'b1);
      chk1(illuminator_shutter_out, 1'b1);
      chk1(analog_power_en, 1'b1);
      settle_check(520 - 3);
      $display("reset test done");
   endtask

   task automatic test_regs();
      u_host.write_reg(7'h00, 8'h05);
      u_host.read_reg(7'h00, rd);
      chk8(rd, 8'h05);
      u_host.write_reg(7'h01, 8'hFF);
      u_host.read_reg(7'h00, rd);
      chk8(rd, 8'h05);
      u_host.read_reg(7'h01, rd);
      chk8(rd, 8'h00);
      $display("register test done");
   endtask

   task automatic test_timeout();
      u_host.send_byte(8'h80);
      repeat (450) @(negedge sys_clk);
      u_host.write_reg(7'h00, 8'h07);
      u_host.read_reg(7'h00, rd);
      chk8(rd, 8'h07);
      $display("timeout test done");
   endtask

   task automatic test_sleep();
      u_host.write_reg(7'h00, 8'h47);
      chk1(sleep_mode, 1'b1);
      chk1(analog_power_en, 1'b0);
      chk1(illuminator_shutter_oe, 1'b0);
      chk1(sdio_oe, 1'b0);
      chk1(motion_valid, 1'b0);
      u_host.write_reg(7'h00, 8'h7A);
      chk1(sleep_mode, 1'b1);
      u_host.send_byte(8'h80);
      repeat (450) @(negedge sys_clk);
      chk1(sleep_mode, 1'b1);
      u_host.send_byte(8'h3A);
      repeat (10) @(negedge sys_clk);
      chk1(sleep_mode, 1'b0);
      chk1(analog_power_en, 1'b1);
      settle_check(770 - 10);
      u_host.read_reg(7'h00, rd);
      chk8(rd, 8'h07);
      $display("sleep test done");
   endtask

   // ************************************************************
   // main sequence and watchdog
   // ************************************************************
   initial begin
      test_reset();
      test_regs();
      test_timeout();
      test_sleep();
      summarize();
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      $display("watchdog expired");
      summarize();
   end
endmodule
